/* hdl/acc_pkg.sv */
// Package with register map, field positions and timing constants of the converter control
package acc_pkg;
    // ==========================================
    // Register map (word index = printed offset / 4 is not needed: all offsets multiple of four)
    localparam logic [7:0] ACC_CTRL_ADDR = 8'hC0;
    localparam logic [7:0] ACC_RESULT_ADDR = 8'hC4;
    localparam logic [7:0] ACC_INDIS_ADDR = 8'hC8;
    localparam logic [7:0] ACC_IRQ_STAT_ADDR = 8'hCC;
    localparam logic [7:0] ACC_IRQ_MASK_ADDR = 8'hD0;
    localparam logic [7:0] ACC_SYS_ADDR = 8'hD4;
    localparam logic [7:0] ACC_PORT_ADDR = 8'hD8;
    // ==========================================
    // Control register fields
    localparam int ACC_EN_BIT = 7;
    localparam int ACC_DAC1_BIT = 6;
    localparam int ACC_RESULT_AND_FIRST_DAC_BIT = 5;
    localparam int ACC_DONE_BIT = 4;
    localparam int ACC_BUSY_BIT = 3;
    localparam int ACC_RC_BIT = 2;
    localparam int ACC_CH_HI_BIT = 1;
    localparam int ACC_CH_LO_BIT = 0;
    localparam logic [7:0] ACC_CTRL_RESET = 8'h00;
    localparam logic [7:0] ACC_INDIS_RESET = 8'h00;
    // System register fields: global interrupt enable, converter interrupt enable, top priority
    localparam int ACC_SYS_GIE_BIT = 0;
    localparam int ACC_SYS_EAD_BIT = 1;
    localparam int ACC_SYS_PRIO_BIT = 2;
    // ==========================================
    // Conversion timing
    localparam int ACC_BITS = 8;
    localparam int ACC_SAMPLE_STEPS = 2;
    localparam int ACC_CLK_MHZ = 250;
    localparam int ACC_STEP_NS = 100;
    localparam int ACC_STEP_CYC = (ACC_STEP_NS * ACC_CLK_MHZ + 999) / 1000;
    localparam logic [31:0] ACC_WB_ZERO = 32'h0000_0000;
    typedef enum logic [2:0] {
        ACC_IDLE = 3'b001,
        ACC_SAMPLE = 3'b010,
        ACC_STEP = 3'b100
    } acc_state_type;
endpackage : acc_pkg

/* hdl/acc_conv_if.sv */
// Interface between the control register logic and the approximation engine
`timescale 1ns/10ps
interface acc_conv_if;
    logic start;
    logic [1:0] channel;
    logic done;
    logic [7:0] result;
    logic busy;
    logic step_en;
    logic comp_hi;
    logic [7:0] trial;
    modport ctrl (output start, output channel, output step_en, input done, input result, input busy, input trial);
    modport eng (input start, input channel, input step_en, output done, output result, output busy, output trial);
    modport cmp (input trial, output comp_hi);
endinterface : acc_conv_if

/* hdl/acc_sar_engine.sv */
// Successive-approximation engine: sampling phase then one step per bit
`timescale 1ns/10ps
module acc_sar_engine
    import acc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic comp_hi_i,
    acc_conv_if.eng cv
);
    acc_state_type state_q;
    logic [3:0] cnt_q;
    logic [7:0] sar_q;
    logic [7:0] bit_q;
    logic done_q;
    wire logic [7:0] keep = comp_hi_i ? sar_q : (sar_q & ~bit_q);
    assign cv.busy = (state_q != ACC_IDLE);
    assign cv.done = done_q;
    assign cv.result = sar_q;
    assign cv.trial = sar_q;
    // ==========================================
    // Sequencer
    always_ff @(posedge clk_i) begin
        done_q <= 1'b0;
        if (rst_i) begin
            state_q <= ACC_IDLE;
            cnt_q <= 4'h0;
            sar_q <= 8'h00;
            bit_q <= 8'h00;
        end else begin
            unique case (state_q)
                ACC_IDLE: begin
                    if (cv.start) begin
                        state_q <= ACC_SAMPLE;
                        cnt_q <= 4'(ACC_SAMPLE_STEPS);
                        sar_q <= 8'h80;
                        bit_q <= 8'h80;
                    end
                end
                ACC_SAMPLE: begin
                    if (cv.step_en) begin
                        cnt_q <= cnt_q - 4'h1;
                        if (cnt_q == 4'h1) begin
                            state_q <= ACC_STEP;
                            cnt_q <= 4'(ACC_BITS);
                        end
                    end
                end
                ACC_STEP: begin
                    if (cv.step_en) begin
                        cnt_q <= cnt_q - 4'h1;
                        sar_q <= keep | (bit_q >> 1);
                        bit_q <= bit_q >> 1;
                        if (cnt_q == 4'h1) begin
                            sar_q <= keep;
                            state_q <= ACC_IDLE;
                            done_q <= 1'b1;
                        end
                    end
                end
                default: state_q <= ACC_IDLE;
            endcase
        end
    end
endmodule : acc_sar_engine

/* hdl/acc_step_div.sv */
// Divider giving the one-cycle conversion step enable
`timescale 1ns/10ps
module acc_step_div
    import acc_pkg::*;
#(
    parameter int STEP_CYC = ACC_STEP_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    acc_conv_if.ctrl cv
);
    logic [15:0] div_q;
    logic en_q;
    assign cv.step_en = en_q;
    always_ff @(posedge clk_i) begin
        if (rst_i || !cv.busy) begin
            div_q <= 16'h0000;
            en_q <= 1'b0;
        end else begin
            en_q <= (div_q == 16'(STEP_CYC - 1));
            div_q <= (div_q == 16'(STEP_CYC - 1)) ? 16'h0000 : div_q + 16'h0001;
        end
    end
endmodule : acc_step_div

/* hdl/acc_ctrl.sv */
// Converter control: register file, start/busy, completion flag, result, input disable, DAC gating
`timescale 1ns/10ps
module acc_ctrl
    import acc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] adr_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    input wire logic we_i,
    input wire logic [3:0] sel_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    output logic ack_o,
    output logic err_o,
    input wire logic comp_hi_i,
    input wire logic [7:0] port_pins_i,
    output logic [1:0] mux_sel_o,
    output logic analog_enable_o,
    output logic first_dac_pin_en_o,
    output logic second_dac_pin_en_o,
    output logic rc_clock_select_o,
    output logic [7:0] sar_trial_o,
    output logic [7:0] port_a_input_disable_o,
    output logic irq_o
);
    acc_conv_if cv ();
    logic [7:0] ctrl_q;
    logic [7:0] result_q;
    logic [7:0] indis_q;
    logic [2:0] sys_q;
    logic mask_q;
    logic stat_q;
    logic ack_q;
    logic err_q;
    logic [31:0] rdat_q;
    logic [7:0] pin_s1_q;
    logic [7:0] pin_s2_q;

    // ==========================================
    // Bus decode
    wire logic req = cyc_i && stb_i && !ack_q && !err_q;
    wire logic hit_ctrl = (adr_i == ACC_CTRL_ADDR);
    wire logic hit_res = (adr_i == ACC_RESULT_ADDR);
    wire logic hit_indis = (adr_i == ACC_INDIS_ADDR);
    wire logic hit_stat = (adr_i == ACC_IRQ_STAT_ADDR);
    wire logic hit_mask = (adr_i == ACC_IRQ_MASK_ADDR);
    wire logic hit_sys = (adr_i == ACC_SYS_ADDR);
    wire logic hit_port = (adr_i == ACC_PORT_ADDR);
    wire logic mapped = hit_ctrl | hit_res | hit_indis | hit_stat | hit_mask | hit_sys | hit_port;
    wire logic wr_lane0 = req && we_i && sel_i[0] && mapped;
    wire logic wr_ctrl = wr_lane0 && hit_ctrl;
    wire logic [7:0] wd = dat_i[7:0];

    // ==========================================
    // Control register behaviour
    wire logic done_evt = cv.done;
    wire logic running = ctrl_q[ACC_BUSY_BIT];
    wire logic blocked = ctrl_q[ACC_BUSY_BIT] | ctrl_q[ACC_DONE_BIT];
    wire logic start_req = wr_ctrl && wd[ACC_BUSY_BIT] && !blocked;
    wire logic clr_done = wr_ctrl && !wd[ACC_DONE_BIT] && ctrl_q[ACC_DONE_BIT];
    wire logic ch_write = wr_ctrl && !running && !clr_done;
    wire logic result_and_first_dac_write = wr_ctrl && !blocked;
    wire logic [1:0] ch_next = ch_write ? wd[ACC_CH_HI_BIT:ACC_CH_LO_BIT] : ctrl_q[ACC_CH_HI_BIT:ACC_CH_LO_BIT];
    wire logic done_next = done_evt | (ctrl_q[ACC_DONE_BIT] & ~clr_done);
    wire logic busy_next = start_req | (running & ~done_evt);
    wire logic [7:0] ctrl_d = {
        wr_ctrl ? wd[ACC_EN_BIT] : ctrl_q[ACC_EN_BIT],
        wr_ctrl ? wd[ACC_DAC1_BIT] : ctrl_q[ACC_DAC1_BIT],
        result_and_first_dac_write ? wd[ACC_RESULT_AND_FIRST_DAC_BIT] : ctrl_q[ACC_RESULT_AND_FIRST_DAC_BIT],
        done_next,
        busy_next,
        wr_ctrl ? wd[ACC_RC_BIT] : ctrl_q[ACC_RC_BIT],
        ch_next
    };

    assign cv.start = start_req;
    assign cv.channel = ch_next;
    assign mux_sel_o = ctrl_q[ACC_CH_HI_BIT:ACC_CH_LO_BIT];
    assign analog_enable_o = ctrl_q[ACC_EN_BIT];
    assign first_dac_pin_en_o = ctrl_q[ACC_RESULT_AND_FIRST_DAC_BIT] && !ctrl_q[ACC_EN_BIT];
    assign second_dac_pin_en_o = ctrl_q[ACC_DAC1_BIT];
    assign rc_clock_select_o = ctrl_q[ACC_RC_BIT];
    assign sar_trial_o = cv.trial;
    assign cv.comp_hi = comp_hi_i;
    assign port_a_input_disable_o = indis_q;

    // ==========================================
    // Interrupt: sticky status, mask, done flag, gated by all three system register bits
    wire logic sys_ok = sys_q[ACC_SYS_GIE_BIT] & sys_q[ACC_SYS_EAD_BIT] & sys_q[ACC_SYS_PRIO_BIT];
    wire logic stat_clr = wr_lane0 && hit_stat && wd[0];
    assign irq_o = stat_q && mask_q && ctrl_q[ACC_DONE_BIT] && sys_ok;

    // ==========================================
    // Port read with disabled inputs forced to zero
    wire logic [7:0] port_rd = pin_s2_q & ~indis_q;

    wire logic [31:0] rd_mux =
        hit_ctrl ? {24'h00_0000, ctrl_q} :
        hit_res ? {24'h00_0000, result_q} :
        hit_indis ? {24'h00_0000, indis_q} :
        hit_stat ? {31'h0000_0000, stat_q} :
        hit_mask ? {31'h0000_0000, mask_q} :
        hit_sys ? {29'h0000_0000, sys_q} :
        hit_port ? {24'h00_0000, port_rd} : ACC_WB_ZERO;

    assign ack_o = ack_q;
    assign err_o = err_q;
    assign dat_o = rdat_q;

    acc_step_div u_div (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .cv(cv.ctrl)
    );

    acc_sar_engine u_eng (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .comp_hi_i(comp_hi_i),
        .cv(cv.eng)
    );

    // ==========================================
    // Registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= ACC_CTRL_RESET;
            indis_q <= ACC_INDIS_RESET;
            sys_q <= 3'b000;
            mask_q <= 1'b0;
            stat_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            if (wr_lane0 && hit_indis) begin
                indis_q <= wd;
            end
            if (wr_lane0 && hit_sys) begin
                sys_q <= wd[2:0];
            end
            if (wr_lane0 && hit_mask) begin
                mask_q <= wd[0];
            end
            stat_q <= done_evt | (stat_q & ~stat_clr);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            result_q <= 8'h00;
        end else if (done_evt) begin
            result_q <= cv.result;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            err_q <= 1'b0;
            rdat_q <= ACC_WB_ZERO;
        end else begin
            ack_q <= req && mapped;
            err_q <= req && !mapped;
            rdat_q <= (req && !we_i) ? rd_mux : ACC_WB_ZERO;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_s1_q <= 8'h00;
            pin_s2_q <= 8'h00;
        end else begin
            pin_s1_q <= port_pins_i;
            pin_s2_q <= pin_s1_q;
        end
    end
endmodule : acc_ctrl

/* verif/acc_ctrl_props.sv */
// Checker of the converter control port behaviour
`timescale 1ns/10ps
module acc_ctrl_props
    import acc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] adr_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic we_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic ack_o,
    input wire logic err_o,
    input wire logic analog_enable_o,
    input wire logic first_dac_pin_en_o,
    input wire logic second_dac_pin_en_o,
    input wire logic rc_clock_select_o,
    input wire logic [7:0] port_a_input_disable_o,
    input wire logic irq_o
);
    // ==========================================
    // Decode
    wire mapped = (adr_i >= ACC_CTRL_ADDR) && (adr_i <= ACC_PORT_ADDR) && (adr_i[1:0] == 2'b00);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ==========================================
    // Properties
    property p_ack_pulse; ack_o |=> !ack_o; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    property p_answer; (cyc_i && stb_i && !ack_o && !err_o) |=> (ack_o || err_o); endproperty
    a_answer: assert property (p_answer) else $error("no answer one cycle after request");
    property p_excl; ack_o |-> !err_o; endproperty
    a_excl: assert property (p_excl) else $error("ack and err together");
    property p_idle_zero; !ack_o |-> (dat_o == ACC_WB_ZERO); endproperty
    a_idle_zero: assert property (p_idle_zero) else $error("read data not zero outside ack");
    property p_err_map; err_o |-> !$past(mapped); endproperty
    a_err_map: assert property (p_err_map) else $error("err on mapped address");
    property p_ack_map; ack_o |-> $past(mapped); endproperty
    a_ack_map: assert property (p_ack_map) else $error("ack on unmapped address");
    property p_upper; ack_o |-> (dat_o[31:8] == 24'h00_0000); endproperty
    a_upper: assert property (p_upper) else $error("upper read bits not zero");
    property p_indis; (ack_o && $past(we_i) && $past(adr_i) == ACC_INDIS_ADDR)
        |-> (port_a_input_disable_o == $past(dat_i[7:0])); endproperty
    a_indis: assert property (p_indis) else $error("input disable write lost");
    property p_ctl_wr; (ack_o && $past(we_i) && $past(adr_i) == ACC_CTRL_ADDR)
        |-> (rc_clock_select_o == $past(dat_i[ACC_RC_BIT]))
        && (second_dac_pin_en_o == $past(dat_i[ACC_DAC1_BIT])); endproperty
    a_ctl_wr: assert property (p_ctl_wr) else $error("control write lost");
    property p_dac_gate; first_dac_pin_en_o |-> !analog_enable_o; endproperty
    a_dac_gate: assert property (p_dac_gate) else $error("first DAC out while enabled");
    property p_port_zero; (ack_o && !$past(we_i) && $past(adr_i) == ACC_PORT_ADDR)
        |-> ((dat_o[7:0] & port_a_input_disable_o) == 8'h00); endproperty
    a_port_zero: assert property (p_port_zero) else $error("disabled pin read one");
    c_err: cover property (err_o);
    c_irq: cover property ($rose(irq_o));
    c_dac: cover property (first_dac_pin_en_o);
endmodule : acc_ctrl_props

bind acc_ctrl acc_ctrl_props props_u (.clk_i, .rst_i, .adr_i, .dat_i, .dat_o, .we_i, .cyc_i, .stb_i,
    .ack_o, .err_o, .analog_enable_o, .first_dac_pin_en_o, .second_dac_pin_en_o, .rc_clock_select_o,
    .port_a_input_disable_o, .irq_o);

/* verif/acc_ctrl_tb.sv */
// Self-checking bench of the converter control block
`timescale 1ns/10ps
module acc_ctrl_tb;
    import acc_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] adr_i = 8'h00;
    logic [31:0] dat_i = ACC_WB_ZERO;
    logic we_i = 1'b0;
    logic [3:0] sel_i = 4'h0;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic [7:0] port_pins_i = 8'h00;
    logic [7:0] vin = 8'h00;
    logic [7:0] ex;
    logic [7:0] dis;
    logic [31:0] dat_o;
    logic [31:0] rd_v;
    logic ack_o, err_o, analog_enable_o, first_dac_pin_en_o, second_dac_pin_en_o, rc_clock_select_o;
    logic irq_o, rd_e;
    logic [1:0] mux_sel_o;
    logic [7:0] sar_trial_o, port_a_input_disable_o;
    wire comp_hi_i = (vin >= sar_trial_o) === 1'b1;
    int err_count = 0;
    int checks = 0;
    localparam int SETTLE_CYC = 2500;
    acc_ctrl dut_u (.clk_i, .rst_i, .adr_i, .dat_i, .dat_o, .we_i, .sel_i, .cyc_i, .stb_i, .ack_o, .err_o,
        .comp_hi_i, .port_pins_i, .mux_sel_o, .analog_enable_o, .first_dac_pin_en_o, .second_dac_pin_en_o,
        .rc_clock_select_o, .sar_trial_o, .port_a_input_disable_o, .irq_o);
    // ==========================================
    // Expectations
    function automatic logic [31:0] res_exp(input logic [7:0] v);
        return {24'h00_0000, v};
    endfunction : res_exp
    function automatic logic [31:0] port_exp(input logic [7:0] p, input logic [7:0] d);
        return {24'h00_0000, p & ~d};
    endfunction : port_exp
    // ==========================================
    // Tasks
    task automatic print_verdict();
        $display("checks %0d errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : print_verdict
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] got);
        checks++;
        if (got !== e) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, got);
        end
    endtask : chk
    task automatic wb(input logic [7:0] a, input logic [31:0] d, input logic w);
        adr_i <= a;
        dat_i <= d;
        we_i <= w;
        sel_i <= 4'hf;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        do begin
            @(posedge clk_i);
        end while (ack_o !== 1'b1 && err_o !== 1'b1);
        rd_v = dat_o;
        rd_e = err_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
    endtask : wb
    // ==========================================
    // Clock, watchdog and tests
    initial begin
        forever #2 clk_i = ~clk_i;
    end
    initial begin
        #200000;
        err_count++;
        print_verdict();
    end
    initial begin
        void'($urandom(24));
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wb(ACC_CTRL_ADDR, ACC_WB_ZERO, 1'b0);
        chk("ctrl reset", {24'h00_0000, ACC_CTRL_RESET}, rd_v);
        wb(8'hE0, 32'h0000_0055, 1'b1);
        chk("unmapped err", 32'h0000_0001, 32'(rd_e));
        wb(ACC_SYS_ADDR, 32'h0000_0007, 1'b1);
        for (int ch = 0; ch < 4; ch++) begin
            vin <= (ch == 0) ? 8'hFF : (ch == 1) ? 8'h00 : 8'($urandom);
            wb(ACC_IRQ_MASK_ADDR, 32'(ch != 3), 1'b1);
            wb(ACC_CTRL_ADDR, 32'h0000_0080, 1'b1);
            chk("enable", 32'h0000_0001, 32'(analog_enable_o));
            repeat (SETTLE_CYC) @(posedge clk_i);
            wb(ACC_CTRL_ADDR, 32'(8'h88 | ch), 1'b1);
            chk("mux sel", 32'(ch), 32'(mux_sel_o));
            wb(ACC_CTRL_ADDR, 32'(8'h88 | (ch ^ 3)), 1'b1);
            wb(ACC_CTRL_ADDR, ACC_WB_ZERO, 1'b0);
            chk("busy", 32'(8'h88 | ch), rd_v);
            for (int k = 0; k < 400 && rd_v[ACC_DONE_BIT] !== 1'b1; k++) wb(ACC_CTRL_ADDR, ACC_WB_ZERO, 1'b0);
            chk("done", 32'(8'h90 | ch), rd_v);
            chk("irq", 32'(ch != 3), 32'(irq_o));
            ex = vin;
            wb(ACC_RESULT_ADDR, ACC_WB_ZERO, 1'b0);
            chk("result", res_exp(ex), rd_v);
            vin <= ~ex;
            wb(ACC_CTRL_ADDR, 32'(8'h98 | ch), 1'b1);
            repeat (300) @(posedge clk_i);
            wb(ACC_CTRL_ADDR, ACC_WB_ZERO, 1'b0);
            chk("start blocked", 32'(8'h90 | ch), rd_v);
            wb(ACC_RESULT_ADDR, ACC_WB_ZERO, 1'b0);
            chk("result held", res_exp(ex), rd_v);
            wb(ACC_CTRL_ADDR, 32'(8'h80 | (ch ^ 1)), 1'b1);
            chk("sel on clear", 32'(ch), 32'(mux_sel_o));
            chk("irq clear", ACC_WB_ZERO, 32'(irq_o));
            wb(ACC_IRQ_STAT_ADDR, 32'h0000_0001, 1'b1);
        end
        for (int i = 0; i < 4; i++) begin
            dis = (i == 0) ? 8'hFF : 8'($urandom);
            port_pins_i <= (i == 1) ? 8'hFF : 8'($urandom);
            wb(ACC_INDIS_ADDR, {24'h00_0000, dis}, 1'b1);
            repeat (3) @(posedge clk_i);
            wb(ACC_PORT_ADDR, ACC_WB_ZERO, 1'b0);
            chk("port read", port_exp(port_pins_i, dis), rd_v);
        end
        wb(ACC_CTRL_ADDR, 32'h0000_0064, 1'b1);
        chk("dac out", 32'h0000_0001, 32'(first_dac_pin_en_o));
        wb(ACC_CTRL_ADDR, ACC_WB_ZERO, 1'b1);
        chk("dac off", ACC_WB_ZERO, 32'(first_dac_pin_en_o));
        print_verdict();
    end
endmodule : acc_ctrl_tb
